// >>> pwd_defines.svh
`ifndef PWD_DEFINES_SVH
`define PWD_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte addresses (duty units are four words from PWD_A_DUTY)
// ----------------------------------------------------------------------
`define PWD_A_DUTY   8'h00
`define PWD_A_OVR    8'h10
`define PWD_A_CTRL   8'h14
`define PWD_A_DTV    8'h18
`define PWD_A_DTS    8'h1C
`define PWD_A_STAT   8'h20

// ----------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------
`define PWD_C_ON     0
`define PWD_C_MODE   1
`define PWD_C_LOCK   3
`define PWD_C_IUE    4
`define PWD_C_OVERRIDE_SYNC_EN  5
`define PWD_C_INDEP  8

// ----------------------------------------------------------------------
// time base mode codes
// ----------------------------------------------------------------------
`define PWD_M_FREE   2'h0
`define PWD_M_CENTER 2'h1
`define PWD_M_SINGLE 2'h2
`define PWD_M_DOUBLE 2'h3

// ----------------------------------------------------------------------
// override word, dead-time value and dead-time assign fields
// ----------------------------------------------------------------------
`define PWD_O_OVDH   12
`define PWD_O_OVDL   8
`define PWD_O_VALH   4
`define PWD_O_VALL   0
`define PWD_D_A      0
`define PWD_D_APS    6
`define PWD_D_B      8
`define PWD_D_BPS    14
`define PWD_S_ACT    0
`define PWD_S_INACT  4

// ----------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------
`define PWD_RST_REG  16'h0000
`define PWD_RESP_OK  2'h0
`define PWD_RESP_ERR 2'h2

`endif

// >>> pwd_pkg.sv
package pwd_pkg;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } pwd_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pwd_axi_rsp_t;

    typedef struct packed {
        logic [14:0] count;
        logic        half;
        logic        down;
        logic [14:0] period;
    } pwd_tb_t;

    typedef struct packed {
        logic [3:0][15:0] duty_buf;
        logic [3:0][15:0] duty_act;
        logic [15:0]      ovr_buf;
        logic [15:0]      ovr_act;
        logic             tb_on;
        logic [1:0]       mode;
        logic             lock;
        logic             instant_update_en;
        logic             override_sync_en;
        logic [3:0]       indep;
        logic [15:0]      dtv;
        logic [7:0]       dts;
        logic [3:0]       cmp_prev;
        logic [3:0][5:0]  dt_cnt;
        logic [3:0][2:0]  psc;
        logic [3:0]       dt_use_b;
        logic [3:0]       hi;
        logic [3:0]       lo;
        logic             pulse_done;
        logic             aw_have;
        logic [7:0]       aw_addr;
        logic             w_have;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        pwd_axi_rsp_t     rsp;
    } pwd_state_t;

endpackage : pwd_pkg

// >>> pwd_top.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "pwd_defines.svh"
// Behaviour
// - four 16-bit duty compare registers
// - duty lsb adds half-step edge resolution
// - buffer plus active compare per unit
// - edge mode reloads at counter reset
// - time base off copies buffers continuously unless locked in edge mode
// - up/down mode reloads at zero upward
// - double update reloads at zero, period
// - instant update applies duty writes at once
// - instant update shortens or lengthens pulse
// - unit n drives pair n, complement low
// - pair complementary when select bit clear
// - 6-bit dead-time counter loaded on edges
// - edge select bits pick dead time A/B
// - separate dead times per switching direction
// - prescale of 1, 2, 4, 8 cycles
// - prescaler cleared on load, config write
// - independent pairs: no dead time, overlap allowed
// - independent pins: pwm, inactive or active
// - single pulse mode, stop at period
// - override: upper enables, lower levels
// - forced low is complement, dead time kept
// - synced override only at counter boundaries
// - edge aligned: active from zero to duty
// - center aligned: active around counter bottom
module pwd_top (
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire pwd_pkg::pwd_axi_req_t bus_req,
    output var  pwd_pkg::pwd_axi_rsp_t bus_rsp,
    input  wire pwd_pkg::pwd_tb_t      tb,
    output logic [3:0]                high_side_out,
    output logic [3:0]                low_side_out,
    output logic                      single_pulse_irq
);

    pwd_pkg::pwd_state_t s_q;
    pwd_pkg::pwd_state_t s_d;

    logic [15:0] pos;
    logic        zero;
    logic        pmatch;
    logic        edge_md;
    logic        sync_pt;
    logic        c;
    logic        src;
    logic        use_b;
    logic        oh;
    logic        ol;
    logic        vh;
    logic        vl;
    logic [15:0] act;
    logic [31:0] nv;
    logic        wr_go;
    logic [7:0]  wr_addr;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a <= `PWD_A_STAT);
    endfunction : addr_ok

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[8*b +: 8] = data[8*b +: 8];
            end
        end
    endfunction : merge

    // prescale code n ticks the dead-time counter every 2^n cycles
    function automatic logic [2:0] psc_mask(input logic [1:0] ps);
        psc_mask = 3'((4'h1 << ps) - 4'h1);
    endfunction : psc_mask

    function automatic logic [31:0] reg_read(input pwd_pkg::pwd_state_t s,
                                             input logic [7:0] a);
        reg_read = 32'h0000_0000;
        if (a < `PWD_A_OVR) begin
            reg_read[15:0] = s.duty_buf[a[3:2]];
        end else begin
            case (a)
                `PWD_A_OVR:  reg_read[15:0] = s.ovr_buf;
                `PWD_A_CTRL: begin
                    reg_read[`PWD_C_ON]         = s.tb_on;
                    reg_read[`PWD_C_MODE +: 2]  = s.mode;
                    reg_read[`PWD_C_LOCK]       = s.lock;
                    reg_read[`PWD_C_IUE]        = s.instant_update_en;
                    reg_read[`PWD_C_OVERRIDE_SYNC_EN]      = s.override_sync_en;
                    reg_read[`PWD_C_INDEP +: 4] = s.indep;
                end
                `PWD_A_DTV:  reg_read[15:0] = s.dtv;
                `PWD_A_DTS:  reg_read[7:0]  = s.dts;
                `PWD_A_STAT: reg_read[11:0] = {s.cmp_prev, s.lo, s.hi};
                default:     reg_read = 32'h0000_0000;
            endcase
        end
    endfunction : reg_read

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d     = s_q;
        c       = 1'b0;
        src     = 1'b0;
        use_b   = 1'b0;
        oh      = 1'b0;
        ol      = 1'b0;
        vh      = 1'b0;
        vl      = 1'b0;
        act     = 16'h0000;
        nv      = 32'h0000_0000;
        wr_go   = 1'b0;
        wr_addr = 8'h00;
        // counter steps are doubled; half marks the later half-step
        pos     = {tb.count, tb.half};
        zero    = (tb.count == 15'h0000);
        pmatch  = (tb.count == tb.period);
        edge_md = (s_q.mode == `PWD_M_FREE) || (s_q.mode == `PWD_M_SINGLE);
        sync_pt = zero || (!edge_md && pmatch);
        s_d.pulse_done = 1'b0;

        // active compare reload at period boundaries
        for (int i = 0; i < 4; i++) begin
            if (!s_q.tb_on) begin
                if (!edge_md || !s_q.lock) begin
                    s_d.duty_act[i] = s_q.duty_buf[i];
                end
            end else if (!s_q.lock) begin
                case (s_q.mode)
                    `PWD_M_FREE, `PWD_M_SINGLE: begin
                        if (zero) begin
                            s_d.duty_act[i] = s_q.duty_buf[i];
                        end
                    end
                    `PWD_M_CENTER: begin
                        if (zero && !tb.down) begin
                            s_d.duty_act[i] = s_q.duty_buf[i];
                        end
                    end
                    default: begin
                        if (zero || pmatch) begin
                            s_d.duty_act[i] = s_q.duty_buf[i];
                        end
                    end
                endcase
            end
        end

        if (!s_q.override_sync_en || sync_pt) begin
            s_d.ovr_act = s_q.ovr_buf;
        end

        // compare, override and dead time per pair
        for (int i = 0; i < 4; i++) begin
            act = s_q.duty_act[i];
            // level compare: an instant duty change moves the edge at once
            if (edge_md) begin
                c = s_q.tb_on && (pos < act);
            end else begin
                c = s_q.tb_on && ((pos < act) ||
                    (act[15:1] == tb.period));
            end
            oh = s_q.ovr_act[`PWD_O_OVDH + i];
            ol = s_q.ovr_act[`PWD_O_OVDL + i];
            vh = s_q.ovr_act[`PWD_O_VALH + i];
            vl = s_q.ovr_act[`PWD_O_VALL + i];
            if (s_q.indep[i]) begin
                s_d.hi[i]     = oh ? vh : c;
                s_d.lo[i]     = ol ? vl : c;
                s_d.dt_cnt[i] = 6'h00;
                src           = c;
            end else begin
                // forced low turns into an inverted high side source (!vl)
                src = oh ? vh : (ol ? !vl : c);
                if (src != s_q.cmp_prev[i]) begin
                    use_b = src ? s_q.dts[`PWD_S_ACT + i]
                                : s_q.dts[`PWD_S_INACT + i];
                    s_d.dt_use_b[i] = use_b;
                    s_d.dt_cnt[i]   = use_b ? s_q.dtv[`PWD_D_B +: 6]
                                            : s_q.dtv[`PWD_D_A +: 6];
                    s_d.psc[i]      = 3'h0;
                end else if (s_q.dt_cnt[i] != 6'h00) begin
                    if (s_q.psc[i] == psc_mask(s_q.dt_use_b[i]
                            ? s_q.dtv[`PWD_D_BPS +: 2]
                            : s_q.dtv[`PWD_D_APS +: 2])) begin
                        s_d.dt_cnt[i] = s_q.dt_cnt[i] - 6'h01;
                        s_d.psc[i]    = 3'h0;
                    end else begin
                        s_d.psc[i] = s_q.psc[i] + 3'h1;
                    end
                end
                // both sides off while the counter runs
                s_d.hi[i] = src && (s_d.dt_cnt[i] == 6'h00);
                s_d.lo[i] = !src && (s_d.dt_cnt[i] == 6'h00);
            end
            s_d.cmp_prev[i] = src;
        end

        if (s_q.tb_on && (s_q.mode == `PWD_M_SINGLE) && pmatch) begin
            s_d.tb_on      = 1'b0;
            s_d.pulse_done = 1'b1;
        end

        // AXI4-Lite write side: address and data taken in either order
        if (s_q.rsp.awready && bus_req.awvalid) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = bus_req.awaddr;
        end
        if (s_q.rsp.wready && bus_req.wvalid) begin
            s_d.w_have = 1'b1;
            s_d.w_data = bus_req.wdata;
            s_d.w_strb = bus_req.wstrb;
        end
        if (s_q.rsp.bvalid && bus_req.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        if (s_d.aw_have && s_d.w_have && !s_q.rsp.bvalid) begin
            wr_go          = 1'b1;
            wr_addr        = s_d.aw_addr;
            s_d.aw_have    = 1'b0;
            s_d.w_have     = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp  = `PWD_RESP_OK;
            nv = merge(reg_read(s_q, wr_addr), s_d.w_data, s_d.w_strb);
            if (!addr_ok(wr_addr)) begin
                s_d.rsp.bresp = `PWD_RESP_ERR;
            end else if (wr_addr < `PWD_A_OVR) begin
                s_d.duty_buf[wr_addr[3:2]] = nv[15:0];
                if (s_q.instant_update_en) begin
                    s_d.duty_act[wr_addr[3:2]] = nv[15:0];
                end
            end else begin
                case (wr_addr)
                    `PWD_A_OVR: begin
                        s_d.ovr_buf = nv[15:0];
                        if (!s_q.override_sync_en) begin
                            s_d.ovr_act = nv[15:0];
                        end
                    end
                    `PWD_A_CTRL: begin
                        s_d.tb_on = nv[`PWD_C_ON];
                        s_d.mode  = nv[`PWD_C_MODE +: 2];
                        s_d.lock  = nv[`PWD_C_LOCK];
                        s_d.instant_update_en   = nv[`PWD_C_IUE];
                        s_d.override_sync_en = nv[`PWD_C_OVERRIDE_SYNC_EN];
                        s_d.indep = nv[`PWD_C_INDEP +: 4];
                    end
                    // running time base gives no safe dead-time change
                    `PWD_A_DTV: begin
                        s_d.dtv = nv[15:0];
                        s_d.psc = '0;
                    end
                    `PWD_A_DTS: begin
                        s_d.dts = nv[7:0];
                        s_d.psc = '0;
                    end
                    default: begin
                    end
                endcase
            end
        end
        s_d.rsp.awready = !s_d.aw_have && !s_d.rsp.bvalid;
        s_d.rsp.wready  = !s_d.w_have && !s_d.rsp.bvalid;

        // read side: one answer at a time
        if (s_q.rsp.rvalid && bus_req.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (s_q.rsp.arready && bus_req.arvalid) begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata  = reg_read(s_q, bus_req.araddr);
            s_d.rsp.rresp  = addr_ok(bus_req.araddr) ? `PWD_RESP_OK
                                                     : `PWD_RESP_ERR;
        end
        s_d.rsp.arready = !s_d.rsp.rvalid;

        if (sys_rst) begin
            s_d          = '0;
            s_d.duty_buf = {4{`PWD_RST_REG}};
            s_d.ovr_buf  = `PWD_RST_REG;
            s_d.dtv      = `PWD_RST_REG;
        end
    end

    always_ff @(posedge core_clk) begin
        s_q <= s_d;
    end

    assign bus_rsp          = s_q.rsp;
    assign high_side_out    = s_q.hi;
    assign low_side_out     = s_q.lo;
    assign single_pulse_irq = s_q.pulse_done;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    AST_EDGE_RELOAD: assert property (
        s_q.tb_on && s_q.mode == `PWD_M_FREE && zero && !s_q.lock &&
        !wr_go |=> s_q.duty_act[0] == $past(s_q.duty_buf[0]))
        else $error("duty not reloaded at counter reset");

    AST_IDLE_COPY: assert property (
        !s_q.tb_on && !s_q.lock && !wr_go
        |=> s_q.duty_act[1] == $past(s_q.duty_buf[1]))
        else $error("idle copy of duty buffer missing");

    AST_INSTANT: assert property (
        wr_go && s_q.instant_update_en && wr_addr == `PWD_A_DUTY && addr_ok(wr_addr)
        |=> s_q.duty_act[0] == s_q.duty_buf[0])
        else $error("instant duty update not applied");

    AST_EDGE_ACTIVE: assert property (
        s_q.tb_on && edge_md && s_q.ovr_act == 16'h0000 &&
        pos < s_q.duty_act[2] |=> s_q.cmp_prev[2] &&
        (!$past(s_q.indep[2]) || high_side_out[2]))
        else $error("edge compare not active below duty");

    AST_NO_OVERLAP: assert property (
        !s_q.indep[0] |-> !(high_side_out[0] && low_side_out[0]))
        else $error("complementary pair both active");

    AST_DT_GAP: assert property (
        !s_q.indep[3] && s_q.dt_cnt[3] != 6'h00
        |-> !high_side_out[3] && !low_side_out[3])
        else $error("pin active during dead time");

    AST_SINGLE_STOP: assert property (
        s_q.tb_on && s_q.mode == `PWD_M_SINGLE && pmatch && !wr_go
        |=> !s_q.tb_on && single_pulse_irq ##1 !single_pulse_irq)
        else $error("single pulse did not stop");

    AST_OVR_SYNC: assert property (
        s_q.override_sync_en && !sync_pt |=> $stable(s_q.ovr_act))
        else $error("synced override changed off boundary");

    AST_INDEP_FORCE: assert property (
        s_q.indep[1] && s_q.ovr_act[`PWD_O_OVDH + 1]
        |=> high_side_out[1] == $past(s_q.ovr_act[`PWD_O_VALH + 1]))
        else $error("independent override level wrong");

    AST_PSC_CLEAR: assert property (
        wr_go && (wr_addr == `PWD_A_DTV || wr_addr == `PWD_A_DTS)
        |=> s_q.psc == '0)
        else $error("dead-time prescaler not cleared");

endmodule : pwd_top
`default_nettype wire

// >>> pwd_bridge_load.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// transistor pair load: shoot-through and dead-gap monitor
// ----------------------------------------------------------------------
module pwd_bridge_load (
    input  wire logic            core_clk,
    input  wire logic            sys_rst,
    input  wire logic [3:0]      high_side_out,
    input  wire logic [3:0]      low_side_out,
    input  wire logic [3:0]      indep,
    output var  int              shoot_cnt,
    output var  logic [3:0][7:0] gap_on,
    output var  logic [3:0][7:0] gap_off
);
    logic [3:0][7:0] off_run;
    logic [3:0]      hi_q;
    logic [3:0]      lo_q;

    always @(posedge core_clk) begin
        hi_q <= high_side_out;
        lo_q <= low_side_out;
        if (sys_rst) begin
            shoot_cnt <= 0;
            off_run   <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                // both devices on shorts the supply
                if (high_side_out[i] && low_side_out[i] && !indep[i])
                    shoot_cnt <= shoot_cnt + 1;
                if (high_side_out[i] || low_side_out[i])
                    off_run[i] <= 8'h00;
                else
                    off_run[i] <= off_run[i] + 8'h01;
                // gap seen before each device turns on
                if (high_side_out[i] && !hi_q[i])
                    gap_on[i] <= off_run[i];
                if (low_side_out[i] && !lo_q[i])
                    gap_off[i] <= off_run[i];
            end
        end
    end
endmodule : pwd_bridge_load
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "pwd_defines.svh"
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
    mismatches++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); \
    end end
module tb;
    localparam int PER = 20;
    logic                  core_clk = 1'b0;
    logic                  sys_rst  = 1'b1;
    pwd_pkg::pwd_axi_req_t req      = '0;
    pwd_pkg::pwd_axi_rsp_t rsp;
    pwd_pkg::pwd_tb_t      tb_in;
    logic [3:0]            hi;
    logic [3:0]            lo;
    logic                  irq;
    int                    mismatches = 0;
    int                    cmp_count  = 0;
    int                    cyc        = 0;
    int                    ph         = 0;
    int                    seed       = 32'h4b79;
    int                    m_buf[4]   = '{0, 0, 0, 0};
    int                    m_act[4]   = '{0, 0, 0, 0};
    logic                  m_on       = 1'b0;
    logic                  m_iue      = 1'b0;
    logic                  chk        = 1'b0;
    logic [3:0]            m_ind      = 4'h0;
    logic [3:0]            e1         = 4'h0;
    int                    shoot;
    logic [3:0][7:0]       g_on;
    logic [3:0][7:0]       g_off;
    logic [1:0]            r;
    logic [31:0]           v;

    always #20 core_clk = ~core_clk;
    // time base: ph is {count, half}, edge-aligned up count
    assign tb_in = '{count: ph[15:1], half: ph[0], down: 1'b0,
                     period: 15'(PER)};

    pwd_top i_dut (
        .core_clk         (core_clk),
        .sys_rst          (sys_rst),
        .bus_req          (req),
        .bus_rsp          (rsp),
        .tb               (tb_in),
        .high_side_out    (hi),
        .low_side_out     (lo),
        .single_pulse_irq (irq)
    );
    pwd_bridge_load i_load (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .high_side_out (hi),
        .low_side_out  (lo),
        .indep         (m_ind),
        .shoot_cnt     (shoot),
        .gap_on        (g_on),
        .gap_off       (g_off)
    );

    task automatic close_out;
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // reference: pins are registered once from the sampled time base
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        ph  <= (ph == 2 * PER + 1) ? 0 : ph + 1;
        for (int i = 0; i < 4; i++) begin
            e1[i] <= m_on && (ph < m_act[i]);
            if (!m_on || ph == 0)
                m_act[i] <= m_buf[i];
        end
        if (cyc == 20000) begin
            mismatches++;
            close_out();
        end
    end

    always @(negedge core_clk) begin
        if (chk) begin
            for (int i = 0; i < 4; i++) begin
                `CHK("pin_high", e1[i], hi[i])
                `CHK("pin_low", e1[i], lo[i])
            end
        end
    end

    // ------------------------------------------------------------------
    // register bus master
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        req.bready  <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (rsp.awready === 1'b1)
                req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1)
                req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1 && n < 100);
        r = rsp.bresp;
        req.bready <= 1'b0;
        if (n >= 100)
            mismatches++;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge core_clk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (rsp.arready === 1'b1)
                req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1 && n < 100);
        v = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        if (n >= 100)
            mismatches++;
    endtask : rd

    task automatic setd(input int i, input int d);
        wr(8'(4 * i), 32'(d));
        m_buf[i] <= d;
        if (m_iue)
            m_act[i] <= d;
    endtask : setd

    // checking paused while the time base switches
    task automatic setc(input logic [31:0] c);
        chk <= 1'b0;
        wr(`PWD_A_CTRL, c);
        m_on  <= c[`PWD_C_ON];
        m_iue <= c[`PWD_C_IUE];
        m_ind <= c[11:8];
        repeat (4) @(posedge core_clk);
    endtask : setc

    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        for (int a = 0; a <= 32; a += 4) begin
            rd(8'(a));
            // stopped complementary pairs keep the low side on
            `CHK("reset_word", (a == 32) ? 32'h0F0 : 32'h0, v)
        end
        rd(8'h24);
        `CHK("unmapped_rresp", `PWD_RESP_ERR, r)
        wr(8'h24, 32'h0);
        `CHK("unmapped_bresp", `PWD_RESP_ERR, r)
        for (int i = 0; i < 4; i++) begin
            wr(8'(4 * i), $random(seed));
            rd(8'(4 * i));
            `CHK("duty_readback", {16'h0, req.wdata[15:0]}, v)
        end
        // ---------------------------------------------------------------
        // edge mode: zero, odd, always-on duty, mid-period rewrite
        // ---------------------------------------------------------------
        setd(0, 0);
        setd(1, 7);
        setd(2, 30);
        setd(3, 2 * PER + 2);
        setc(32'h0F01);
        chk <= 1'b1;
        repeat (2 * (2 * PER + 2)) @(posedge core_clk);
        while (ph != 4) @(posedge core_clk);
        for (int i = 0; i < 4; i++)
            setd(i, ($random(seed) & 31) + 8);
        repeat (3 * (2 * PER + 2)) @(posedge core_clk);
        // immediate update: lengthen then shorten mid-pulse
        setc(32'h0F11);
        chk <= 1'b1;
        while (ph != 20) @(posedge core_clk);
        chk <= 1'b0;
        setd(0, 40);
        setd(1, 2);
        repeat (2) @(posedge core_clk);
        chk <= 1'b1;
        repeat (2 * PER + 2) @(posedge core_clk);
        // ---------------------------------------------------------------
        // override, first unsynced then synced to counter zero
        // ---------------------------------------------------------------
        chk <= 1'b0;
        wr(`PWD_A_OVR, 32'hFF5A);
        @(negedge core_clk);
        `CHK("ovr_high", 4'h5, hi)
        `CHK("ovr_low", 4'hA, lo)
        setc(32'h0F21);
        while (ph != 10) @(posedge core_clk);
        wr(`PWD_A_OVR, 32'hFFA5);
        @(negedge core_clk);
        `CHK("ovr_sync_hold", 4'h5, hi)
        while (ph != 0) @(posedge core_clk);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("ovr_sync_land", 4'hA, hi)
        // ---------------------------------------------------------------
        // complementary pairs, A=3 at 2 cycles, B=5 at 1 cycle
        // ---------------------------------------------------------------
        setc(32'h0000);
        wr(`PWD_A_OVR, 32'h0);
        wr(`PWD_A_DTV, 32'h0543);
        wr(`PWD_A_DTS, 32'hF0);
        for (int i = 0; i < 4; i++)
            setd(i, 20);
        setc(32'h0001);
        repeat (4 * (2 * PER + 2)) @(posedge core_clk);
        for (int i = 0; i < 4; i++) begin
            `CHK("gap_before_high", 8'd6, g_on[i])
            `CHK("gap_before_low", 8'd5, g_off[i])
        end
        `CHK("shoot_through", 0, shoot)
        // ---------------------------------------------------------------
        // single pulse: stops at period match with one pulse out
        // ---------------------------------------------------------------
        setc(32'h0000);
        for (int i = 0; i < 4; i++)
            setd(i, 10);
        setc(32'h0F05);
        for (int n = 0; n < 200 && irq !== 1'b1; n++)
            @(posedge core_clk);
        `CHK("pulse_irq", 1'b1, irq)
        repeat (2) @(posedge core_clk);
        rd(`PWD_A_CTRL);
        `CHK("pulse_stops_base", 1'b0, v[`PWD_C_ON])
        `CHK("pulse_pins_idle", 4'h0, hi)
        close_out();
    end
endmodule : tb
`default_nettype wire
